// ==== src/fsi_dev.sv ====
// fsi_dev.sv: drive end - communication state machine, lamps, mailbox and process data
// assumes: master end on fsi_link_if in the same clock domain; port inputs synchronous
`include "fsi_map.svh"
`timescale 1ns/10ps
`default_nettype none
module fsi_dev #(
	parameter int unsigned BLINK_CYC = `FSI_BLINK_MS * `FSI_CLK_KHZ,
	parameter int unsigned DARK_CYC  = `FSI_DARK_MS * `FSI_CLK_KHZ,
	parameter int unsigned FLICK_CYC = `FSI_FLICK_MS * `FSI_CLK_KHZ
) (
	// clock, reset, enable
	input  wire logic                   MCLK_I,
	input  wire logic                   NRST_I,
	input  wire logic                   CE_I,
	// link to the master
	fsi_link_if.dev                     lnk,
	// network ports: bit 0 network_in_port, bit 1 network_out_port
	input  wire logic [1:0]             PORT_LINK_I,
	input  wire logic [1:0]             PORT_ACT_I,
	// application side
	input  wire logic                   DC_MODE_I,
	input  wire logic                   ALARM_I,
	input  wire logic [`FSI_PD_W-1:0]   ALARM_CODE_I,
	input  wire logic [`FSI_PD_W-1:0]   PD_IN_DATA_I,
	output logic                        PD_OUT_VALID_O,
	output logic [`FSI_PD_W-1:0]        PD_OUT_DATA_O,
	output logic                        APP_TICK_O,
	output fsi_pkg::fsi_al_e            AL_STATE_O,
	output logic [`FSI_PD_W-1:0]        CYCLE_TIME_O,
	// lamps
	output logic                        RUN_LAMP_O,
	output logic                        ERR_LAMP_O,
	output logic [1:0]                  PORT_LINK_ACTIVITY_LAMP_O
);
	localparam int unsigned LW = $clog2(`FSI_FIFO_DEPTH) + 1;
	typedef struct packed {
		fsi_pkg::fsi_al_e              al;
		logic                          ack;
		logic                          err;
		logic                          blink;
		fsi_pkg::fsi_tim_t             blink_cnt;
		fsi_pkg::fsi_tim_t             flash_cnt;
		logic                          flick;
		fsi_pkg::fsi_tim_t             flick_cnt;
		logic [1:0][24:0]              act_hold;
		logic                          run_lamp;
		logic                          err_lamp;
		logic [1:0]                    port_lamp;
		logic [`FSI_PD_W-1:0]          cyc_time;
		logic [`FSI_PD_W-1:0]          app_cnt;
		logic                          app_tick;
		logic                          out_seen;
		logic                          pdo_valid;
		logic [`FSI_PD_W-1:0]          pdo_data;
		logic                          pdi_valid;
		logic [`FSI_PD_W-1:0]          pdi_data;
		logic                          tx_valid;
		logic                          tx_emcy;
		logic                          tx_abort;
		logic [`FSI_PD_W-1:0]          tx_data;
		logic                          emcy_pend;
		logic [`FSI_PD_W-1:0]          emcy_code;
		logic                          mbx_ready;
	} fsi_dev_s;

	fsi_dev_s                  r_reg;
	fsi_dev_s                  r_next;
	logic                      fifo_in_ready;
	logic                      fifo_out_valid;
	logic                      fifo_out_ready;
	logic [`FSI_MBX_W-1:0]     fifo_out_data;
	logic [LW-1:0]             fifo_level;
	logic                      emcy_go;

	// an emergency owns the answer slot, so the mailbox queue stalls behind it
	assign emcy_go        = r_reg.emcy_pend && (r_reg.al != fsi_pkg::AL_INIT);
	assign fifo_out_ready = !emcy_go;

	// mailbox requests queue here; mbx_ready already accounts for its level
	fsi_fifo #(
		.WIDTH (`FSI_MBX_W),
		.DEPTH (`FSI_FIFO_DEPTH)
	) u_mbx_fifo (
		.clk_i       (MCLK_I),
		.rst_n_i     (NRST_I),
		.ce_i        (CE_I),
		.in_valid_i  (lnk.mbx_valid && r_reg.mbx_ready),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (lnk.mbx_data),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (fifo_out_ready),
		.out_data_o  (fifo_out_data),
		.level_o     (fifo_level)
	);

	// next-state logic for the whole end
	always_comb begin
		logic          ok;
		logic          push;
		logic          pop;
		logic [LW-1:0] lvl;
		r_next           = r_reg;
		ok               = 1'b0;
		push             = lnk.mbx_valid && r_reg.mbx_ready && fifo_in_ready;
		pop              = fifo_out_valid && fifo_out_ready;
		lvl              = fifo_level;
		r_next.ack       = 1'b0;
		r_next.app_tick  = 1'b0;
		r_next.pdo_valid = 1'b0;
		r_next.pdi_valid = 1'b0;
		r_next.tx_valid  = 1'b0;
		r_next.tx_emcy   = 1'b0;
		r_next.tx_abort  = 1'b0;

		// state requests from the master
		if (lnk.al_req_valid) begin
			r_next.ack = 1'b1; // RULE17
			case (lnk.al_req_state)
				fsi_pkg::AL_INIT: ok = 1'b1;
				fsi_pkg::AL_PREOP: ok = (r_reg.al != fsi_pkg::AL_INIT) || lnk.cfg_mbx; // RULE10
				fsi_pkg::AL_SAFEOP: ok = (r_reg.al == fsi_pkg::AL_OP)
					|| (r_reg.al == fsi_pkg::AL_SAFEOP)
					|| ((r_reg.al == fsi_pkg::AL_PREOP) && lnk.cfg_pd
					&& (!DC_MODE_I || lnk.cfg_dc)); // RULE13
				fsi_pkg::AL_OP: ok = (r_reg.al == fsi_pkg::AL_OP)
					|| ((r_reg.al == fsi_pkg::AL_SAFEOP) && r_reg.out_seen);
				default: ok = 1'b0;
			endcase
			if (ok) begin
				r_next.al  = lnk.al_req_state;
				r_next.err = 1'b0;
			end else begin
				r_next.err = 1'b1; // RULE22
			end
		end

		// application cycle: follows Sync0 in clock mode, else free-runs on the cycle time
		if (DC_MODE_I ? lnk.sync0 : ({1'b0, r_reg.app_cnt} + 17'h00001 >= {1'b0, r_reg.cyc_time})) begin
			r_next.app_tick = 1'b1; // RULE20
			r_next.app_cnt  = '0;
		end else begin
			r_next.app_cnt = r_reg.app_cnt + 1'b1;
		end

		// inputs go out once per cycle in SafeOp and Op only
		if (r_reg.app_tick && (r_reg.al == fsi_pkg::AL_SAFEOP || r_reg.al == fsi_pkg::AL_OP)) begin
			r_next.pdi_valid = 1'b1; // RULE14 RULE16 RULE18
			r_next.pdi_data  = PD_IN_DATA_I;
		end

		// outputs are applied only in Op; SafeOp just notes that valid ones arrived
		if (lnk.pd_out_valid) begin
			if (r_reg.al == fsi_pkg::AL_OP) begin
				r_next.pdo_valid = 1'b1; // RULE16
				r_next.pdo_data  = lnk.pd_out_data;
			end
			if (r_reg.al == fsi_pkg::AL_SAFEOP) begin
				r_next.out_seen = 1'b1; // RULE14
			end
		end
		if (r_next.al == fsi_pkg::AL_INIT || r_next.al == fsi_pkg::AL_PREOP) begin
			r_next.out_seen = 1'b0; // RULE11
		end

		// mailbox answers; emergencies first, queued entries discarded in Init
		if (emcy_go) begin
			r_next.tx_valid  = 1'b1; // RULE19
			r_next.tx_emcy   = 1'b1;
			r_next.tx_data   = r_reg.emcy_code;
			r_next.emcy_pend = 1'b0;
		end else if (pop && r_reg.al != fsi_pkg::AL_INIT) begin
			r_next.tx_valid = 1'b1;
			if (fifo_out_data[`FSI_MBX_W-1:`FSI_SUB_POS] == `FSI_SUB_CYCLE) begin
				r_next.cyc_time = fifo_out_data[`FSI_PD_W-1:0]; // RULE21
				r_next.tx_data  = fifo_out_data[`FSI_PD_W-1:0];
			end else begin
				r_next.tx_abort = 1'b1; // RULE21
				r_next.tx_data  = {8'h00, fifo_out_data[`FSI_MBX_W-1:`FSI_SUB_POS]};
			end
		end
		// a new alarm wins over the send that clears the previous one
		if (ALARM_I) begin
			r_next.emcy_pend = 1'b1; // RULE19
			r_next.emcy_code = ALARM_CODE_I;
		end

		// mailbox accepts only outside Init and while the queue has room
		if (push && !pop) begin
			lvl = fifo_level + 1'b1;
		end else if (pop && !push) begin
			lvl = fifo_level - 1'b1;
		end
		r_next.mbx_ready = (r_next.al != fsi_pkg::AL_INIT)
			&& (lvl < LW'(`FSI_FIFO_DEPTH)); // RULE8 RULE11

		// shared 0.2 s blink phase for run and error lamps
		if (fsi_pkg::tim_end(r_reg.blink_cnt, fsi_pkg::fsi_tim_t'(BLINK_CYC))) begin
			r_next.blink_cnt = '0;
			r_next.blink     = !r_reg.blink;
		end else begin
			r_next.blink_cnt = r_reg.blink_cnt + 1'b1;
		end
		// single flash restarts on entry to SafeOp so it opens with a lit phase
		if (r_reg.al != fsi_pkg::AL_SAFEOP
			|| fsi_pkg::tim_end(r_reg.flash_cnt, fsi_pkg::fsi_tim_t'(BLINK_CYC + DARK_CYC))) begin
			r_next.flash_cnt = '0;
		end else begin
			r_next.flash_cnt = r_reg.flash_cnt + 1'b1;
		end
		case (r_reg.al)
			fsi_pkg::AL_INIT: r_next.run_lamp = 1'b0; // RULE1
			fsi_pkg::AL_PREOP: r_next.run_lamp = r_reg.blink; // RULE2
			fsi_pkg::AL_SAFEOP: r_next.run_lamp = (r_reg.flash_cnt < fsi_pkg::fsi_tim_t'(BLINK_CYC)); // RULE2
			fsi_pkg::AL_OP: r_next.run_lamp = 1'b1; // RULE1
			default: r_next.run_lamp = 1'b0;
		endcase
		r_next.err_lamp = r_reg.err && r_reg.blink; // RULE3 RULE4

		// port lamps: activity stretched so short frames still show a flicker
		if (fsi_pkg::tim_end(r_reg.flick_cnt, fsi_pkg::fsi_tim_t'(FLICK_CYC))) begin
			r_next.flick_cnt = '0;
			r_next.flick     = !r_reg.flick;
		end else begin
			r_next.flick_cnt = r_reg.flick_cnt + 1'b1;
		end
		for (int p = 0; p < 2; p++) begin
			if (PORT_ACT_I[p]) begin
				r_next.act_hold[p] = fsi_pkg::fsi_tim_t'(2 * FLICK_CYC);
			end else if (r_reg.act_hold[p] != '0) begin
				r_next.act_hold[p] = r_reg.act_hold[p] - 1'b1;
			end
			if (!PORT_LINK_I[p]) begin
				r_next.port_lamp[p] = 1'b0; // RULE5
			end else if (r_reg.act_hold[p] != '0) begin
				r_next.port_lamp[p] = r_reg.flick; // RULE6
			end else begin
				r_next.port_lamp[p] = 1'b1; // RULE7
			end
		end
	end

	// state register, frozen while CE_I is low
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			r_reg          <= '0;
			r_reg.cyc_time <= `FSI_CYC_RST;
		end else if (CE_I) begin
			r_reg <= r_next;
		end
	end

	// link outputs
	assign lnk.al_state    = r_reg.al;
	assign lnk.al_ack      = r_reg.ack;
	assign lnk.al_err      = r_reg.err;
	assign lnk.mbx_ready   = r_reg.mbx_ready;
	assign lnk.tx_valid    = r_reg.tx_valid;
	assign lnk.tx_emcy     = r_reg.tx_emcy;
	assign lnk.tx_abort    = r_reg.tx_abort;
	assign lnk.tx_data     = r_reg.tx_data;
	assign lnk.pd_in_valid = r_reg.pdi_valid;
	assign lnk.pd_in_data  = r_reg.pdi_data;

	// user-side outputs
	assign PD_OUT_VALID_O            = r_reg.pdo_valid;
	assign PD_OUT_DATA_O             = r_reg.pdo_data;
	assign APP_TICK_O                = r_reg.app_tick;
	assign AL_STATE_O                = r_reg.al;
	assign CYCLE_TIME_O              = r_reg.cyc_time;
	assign RUN_LAMP_O                = r_reg.run_lamp;
	assign ERR_LAMP_O                = r_reg.err_lamp;
	assign PORT_LINK_ACTIVITY_LAMP_O = r_reg.port_lamp;
endmodule
`default_nettype wire

// ==== src/fsi_map.svh ====
// fsi_map.svh: timing, width and reset constants of the fieldbus state and lamp block
// assumes: included by its bare name from every file that needs a constant
// Notes on behaviour
// [RULE1] run lamp dark in Init, lit in Op
// [RULE2] run lamp blinks in PreOp, single-flashes in SafeOp
// [RULE3] error lamp dark without an error
// [RULE4] refused state change blinks the error lamp
// [RULE5] port lamp dark without link
// [RULE6] port lamp flickers while frames pass
// [RULE7] port lamp steady with idle link
// [RULE8] Init refuses mailbox and process data
// [RULE9] master sets mailbox, address, clock, then requests PreOp; here only cfg_mbx precedes PreOp, cfg_dc is set before SafeOp
// [RULE10] device checks mailbox setup before PreOp
// [RULE11] PreOp serves mailbox, refuses process data
// [RULE12] master sets process data channels, then requests SafeOp
// [RULE13] device checks process data and clock setup
// [RULE14] SafeOp sends inputs, ignores outputs
// [RULE15] master sends outputs before requesting Op
// [RULE16] Op exchanges inputs and outputs
// [RULE17] device state follows master requests
// [RULE18] process data exchanged once per cycle
// [RULE19] alarm sends emergency message with code
// [RULE20] application cycle aligned to Sync0
// [RULE21] only cycle-time subentry is writable
// [RULE22] failed check keeps state, flags error
`ifndef FSI_MAP_SVH
`define FSI_MAP_SVH
`define FSI_CLK_KHZ    20000
`define FSI_BLINK_MS   200
`define FSI_DARK_MS    1000
`define FSI_FLICK_MS   50
`define FSI_SYNC_US    1000
`define FSI_FIFO_DEPTH 32
`define FSI_MBX_W      24
`define FSI_PD_W       16
`define FSI_SUB_POS    16
`define FSI_SUB_CYCLE  8'h03
`define FSI_CYC_RST    16'h4e20
`define FSI_CFG_MBX    0
`define FSI_CFG_PD     1
`define FSI_CFG_DC     2
`endif

// ==== src/fsi_pkg.sv ====
// fsi_pkg.sv: types and shared helpers of the fieldbus state and lamp block
// assumes: compiled before every other file of the block
package fsi_pkg;
	typedef enum logic [1:0] {AL_INIT, AL_PREOP, AL_SAFEOP, AL_OP} fsi_al_e;
	typedef enum logic [1:0] {MS_IDLE, MS_CONFIG, MS_REQ, MS_WAIT} fsi_mst_e;
	typedef logic [24:0] fsi_tim_t;

	// true on the last cycle of a period of lim cycles
	function automatic logic tim_end(input fsi_tim_t cnt, input fsi_tim_t lim);
		tim_end = (cnt >= fsi_tim_t'(lim - 1'b1));
	endfunction
endpackage

// ==== src/fsi_link_if.sv ====
// fsi_link_if.sv: link between the drive end and the master end
// assumes: both ends run on the same clock, all signals change on its rising edge
`include "fsi_map.svh"
`timescale 1ns/10ps
`default_nettype none
interface fsi_link_if (input wire logic mclk);
	fsi_pkg::fsi_al_e             al_req_state;
	logic                         al_req_valid;
	fsi_pkg::fsi_al_e             al_state;
	logic                         al_ack;
	logic                         al_err;
	logic                         cfg_mbx;
	logic                         cfg_pd;
	logic                         cfg_dc;
	logic                         mbx_valid;
	logic [`FSI_MBX_W-1:0]        mbx_data;
	logic                         mbx_ready;
	logic                         tx_valid;
	logic                         tx_emcy;
	logic                         tx_abort;
	logic [`FSI_PD_W-1:0]         tx_data;
	logic                         sync0;
	logic                         pd_out_valid;
	logic [`FSI_PD_W-1:0]         pd_out_data;
	logic                         pd_in_valid;
	logic [`FSI_PD_W-1:0]         pd_in_data;

	modport dev (input al_req_state, al_req_valid, cfg_mbx, cfg_pd, cfg_dc, mbx_valid, mbx_data,
		sync0, pd_out_valid, pd_out_data,
		output al_state, al_ack, al_err, mbx_ready, tx_valid, tx_emcy, tx_abort, tx_data,
		pd_in_valid, pd_in_data);
	modport mst (output al_req_state, al_req_valid, cfg_mbx, cfg_pd, cfg_dc, mbx_valid, mbx_data,
		sync0, pd_out_valid, pd_out_data,
		input al_state, al_ack, al_err, mbx_ready, tx_valid, tx_emcy, tx_abort, tx_data,
		pd_in_valid, pd_in_data);
endinterface
`default_nettype wire

// ==== src/fsi_fifo.sv ====
// fsi_fifo.sv: flip-flop FIFO with valid/ready on both sides
// assumes: DEPTH is a power of two; one clock, asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module fsi_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 32
) (
	// clock and control
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     ce_i,
	// filling side
	input  wire logic                     in_valid_i,
	output logic                          in_ready_o,
	input  wire logic [WIDTH-1:0]         in_data_i,
	// draining side
	output logic                          out_valid_o,
	input  wire logic                     out_ready_i,
	output logic [WIDTH-1:0]              out_data_o,
	output logic [$clog2(DEPTH):0]        level_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} fsi_fifo_s;
	fsi_fifo_s r_reg;
	fsi_fifo_s r_next;
	logic      push;
	logic      pop;

	// flags come from the count flop, so full and empty are exact
	assign in_ready_o  = (r_reg.cnt != (AW+1)'(DEPTH));
	assign out_valid_o = (r_reg.cnt != '0);
	assign out_data_o  = r_reg.mem[r_reg.rp];
	assign level_o     = r_reg.cnt;

	// pointer and count update
	always_comb begin
		push   = in_valid_i && in_ready_o;
		pop    = out_valid_o && out_ready_i;
		r_next = r_reg;
		if (push) begin
			r_next.mem[r_reg.wp] = in_data_i;
			r_next.wp            = r_reg.wp + 1'b1;
		end
		if (pop) begin
			r_next.rp = r_reg.rp + 1'b1;
		end
		if (push && !pop) begin
			r_next.cnt = r_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			r_next.cnt = r_reg.cnt - 1'b1;
		end
	end

	// state register, frozen while ce_i is low
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r_reg <= '0;
		end else if (ce_i) begin
			r_reg <= r_next;
		end
	end
endmodule
`default_nettype wire

// ==== src/fsi_mst.sv ====
// fsi_mst.sv: master end - walks the drive through its states, Sync0, mailbox and process data
// assumes: drive end on fsi_link_if in the same clock domain
`include "fsi_map.svh"
`timescale 1ns/10ps
`default_nettype none
module fsi_mst #(
	parameter int unsigned SYNC_CYC = `FSI_SYNC_US * `FSI_CLK_KHZ / 1000
) (
	// clock, reset, enable
	input  wire logic                   MCLK_I,
	input  wire logic                   NRST_I,
	input  wire logic                   CE_I,
	// link to the drive
	fsi_link_if.mst                     lnk,
	// state goal and deliberate setup faults
	input  wire logic                   GOAL_VALID_I,
	input  wire fsi_pkg::fsi_al_e       GOAL_STATE_I,
	input  wire logic [2:0]             CFG_FAULT_I,
	output fsi_pkg::fsi_al_e            STATE_O,
	output logic                        FAIL_O,
	// object writes
	input  wire logic                   SDO_VALID_I,
	input  wire logic [7:0]             SDO_SUB_I,
	input  wire logic [`FSI_PD_W-1:0]   SDO_VAL_I,
	output logic                        SDO_READY_O,
	output logic                        RSP_VALID_O,
	output logic                        RSP_ABORT_O,
	output logic                        EMCY_VALID_O,
	output logic [`FSI_PD_W-1:0]        MSG_DATA_O,
	// process data
	input  wire logic [`FSI_PD_W-1:0]   PD_OUT_I,
	output logic                        PD_IN_VALID_O,
	output logic [`FSI_PD_W-1:0]        PD_IN_O
);
	typedef struct packed {
		fsi_pkg::fsi_mst_e      fsm;
		fsi_pkg::fsi_al_e       goal;
		fsi_pkg::fsi_al_e       step;
		logic                   fail;
		logic                   cfg_mbx;
		logic                   cfg_pd;
		logic                   cfg_dc;
		logic                   out_sent;
		logic                   req_valid;
		logic                   hold_valid;
		logic [`FSI_MBX_W-1:0]  hold_data;
		fsi_pkg::fsi_tim_t      sync_cnt;
		logic                   sync0;
		logic                   pdo_valid;
		logic [`FSI_PD_W-1:0]   pdo_data;
		logic                   pdi_valid;
		logic [`FSI_PD_W-1:0]   pdi_data;
		logic                   rsp_valid;
		logic                   rsp_abort;
		logic                   emcy_valid;
		logic [`FSI_PD_W-1:0]   msg_data;
	} fsi_mst_s;
	fsi_mst_s r_reg;
	fsi_mst_s r_next;

	// next-state logic
	always_comb begin
		r_next            = r_reg;
		r_next.req_valid  = 1'b0;
		r_next.sync0      = 1'b0;
		r_next.pdo_valid  = 1'b0;
		r_next.pdi_valid  = 1'b0;
		r_next.rsp_valid  = 1'b0;
		r_next.emcy_valid = 1'b0;
		if (GOAL_VALID_I) begin
			r_next.goal = GOAL_STATE_I;
			r_next.fail = 1'b0;
		end
		// one step at a time upward, straight down when lowering
		case (r_reg.fsm)
			fsi_pkg::MS_IDLE: if (r_reg.goal > lnk.al_state) begin
				r_next.step     = fsi_pkg::fsi_al_e'(lnk.al_state + 1'b1);
				r_next.out_sent = 1'b0;
				r_next.fsm      = fsi_pkg::MS_CONFIG;
			end else if (r_reg.goal < lnk.al_state) begin
				r_next.step = r_reg.goal;
				r_next.fsm  = fsi_pkg::MS_REQ;
			end
			fsi_pkg::MS_CONFIG: case (r_reg.step)
				fsi_pkg::AL_PREOP: begin
					r_next.cfg_mbx = !CFG_FAULT_I[`FSI_CFG_MBX]; // RULE9
					r_next.fsm     = fsi_pkg::MS_REQ;
				end
				fsi_pkg::AL_SAFEOP: begin
					r_next.cfg_pd = !CFG_FAULT_I[`FSI_CFG_PD]; // RULE12
					r_next.cfg_dc = !CFG_FAULT_I[`FSI_CFG_DC];
					r_next.fsm    = fsi_pkg::MS_REQ;
				end
				fsi_pkg::AL_OP: if (r_reg.out_sent) begin
					r_next.fsm = fsi_pkg::MS_REQ; // RULE15
				end
				default: r_next.fsm = fsi_pkg::MS_REQ;
			endcase
			fsi_pkg::MS_REQ: begin
				r_next.req_valid = 1'b1; // RULE9 RULE12 RULE15
				r_next.fsm       = fsi_pkg::MS_WAIT;
				if (r_reg.step == fsi_pkg::AL_INIT) begin
					r_next.cfg_mbx = 1'b0;
					r_next.cfg_pd  = 1'b0;
					r_next.cfg_dc  = 1'b0;
				end
			end
			fsi_pkg::MS_WAIT: if (lnk.al_ack) begin
				if (lnk.al_err) begin
					r_next.fail = 1'b1;
					r_next.goal = lnk.al_state;
				end
				r_next.fsm = fsi_pkg::MS_IDLE;
			end
			default: r_next.fsm = fsi_pkg::MS_IDLE;
		endcase
		// Sync0 each network cycle, plus one output frame per cycle in SafeOp and Op
		if (fsi_pkg::tim_end(r_reg.sync_cnt, fsi_pkg::fsi_tim_t'(SYNC_CYC))) begin
			r_next.sync_cnt = '0;
			r_next.sync0    = 1'b1;
			if (lnk.al_state == fsi_pkg::AL_SAFEOP || lnk.al_state == fsi_pkg::AL_OP) begin
				r_next.pdo_valid = 1'b1; // RULE18
				r_next.pdo_data  = PD_OUT_I;
				r_next.out_sent  = 1'b1;
			end
		end else begin
			r_next.sync_cnt = r_reg.sync_cnt + 1'b1;
		end
		if (lnk.pd_in_valid) begin
			r_next.pdi_valid = 1'b1;
			r_next.pdi_data  = lnk.pd_in_data;
		end
		// mailbox answers and emergencies
		if (lnk.tx_valid) begin
			r_next.rsp_valid  = !lnk.tx_emcy;
			r_next.emcy_valid = lnk.tx_emcy;
			r_next.rsp_abort  = lnk.tx_abort;
			r_next.msg_data   = lnk.tx_data;
		end
		// one-entry holding stage for object writes
		if (r_reg.hold_valid && lnk.mbx_ready) begin
			r_next.hold_valid = 1'b0;
		end else if (!r_reg.hold_valid && SDO_VALID_I) begin
			r_next.hold_valid = 1'b1;
			r_next.hold_data  = {SDO_SUB_I, SDO_VAL_I};
		end
	end

	// state register, frozen while CE_I is low
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			r_reg <= '0;
		end else if (CE_I) begin
			r_reg <= r_next;
		end
	end

	// link and user-side outputs
	assign lnk.al_req_valid = r_reg.req_valid;
	assign lnk.al_req_state = r_reg.step;
	assign lnk.cfg_mbx      = r_reg.cfg_mbx;
	assign lnk.cfg_pd       = r_reg.cfg_pd;
	assign lnk.cfg_dc       = r_reg.cfg_dc;
	assign lnk.mbx_valid    = r_reg.hold_valid;
	assign lnk.mbx_data     = r_reg.hold_data;
	assign lnk.sync0        = r_reg.sync0;
	assign lnk.pd_out_valid = r_reg.pdo_valid;
	assign lnk.pd_out_data  = r_reg.pdo_data;
	assign STATE_O          = r_reg.goal;
	assign FAIL_O           = r_reg.fail;
	assign SDO_READY_O      = !r_reg.hold_valid;
	assign RSP_VALID_O      = r_reg.rsp_valid;
	assign RSP_ABORT_O      = r_reg.rsp_abort;
	assign EMCY_VALID_O     = r_reg.emcy_valid;
	assign MSG_DATA_O       = r_reg.msg_data;
	assign PD_IN_VALID_O    = r_reg.pdi_valid;
	assign PD_IN_O          = r_reg.pdi_data;
endmodule
`default_nettype wire

// ==== bench/fsi_assertions.sv ====
// fsi_assertions.sv: checks on the link between the two ends
// assumes: drive in DC mode, enable held high
`timescale 1ns/10ps
`default_nettype none
module fsi_assertions (
	// clock and reset
	input wire logic             mclk,
	input wire logic             NRST_I,
	// link signals
	input wire logic             al_req_valid,
	input wire fsi_pkg::fsi_al_e al_req_state,
	input wire fsi_pkg::fsi_al_e al_state,
	input wire logic             al_ack,
	input wire logic             al_err,
	input wire logic             cfg_mbx,
	input wire logic             cfg_pd,
	input wire logic             mbx_ready,
	input wire logic             sync0,
	input wire logic             pd_in_valid
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!NRST_I);
	property p_ack; al_req_valid |=> al_ack; endproperty
	a_ack: assert property (p_ack) else $error("no ack");
	property p_keep; !al_req_valid |=> $stable(al_state); endproperty
	a_keep: assert property (p_keep) else $error("state moved");
	property p_init; (al_state == 2'h0) [*2] |-> !mbx_ready; endproperty
	a_init: assert property (p_init) else $error("mailbox in init");
	property p_nopd; (!al_state[1]) [*3] |-> !pd_in_valid; endproperty
	a_nopd: assert property (p_nopd) else $error("early inputs");
	property p_in; sync0 && al_state[1] ##1 al_state[1] |=> pd_in_valid; endproperty
	a_in: assert property (p_in) else $error("no inputs");
	property p_once; pd_in_valid |=> (!pd_in_valid) [*8]; endproperty
	a_once: assert property (p_once) else $error("inputs twice");
	property p_mbx; al_req_valid && al_state == 2'h0 && al_req_state == 2'h1 && !cfg_mbx
		|=> al_err && al_state == 2'h0; endproperty
	a_mbx: assert property (p_mbx) else $error("bad mailbox taken");
	property p_pd; al_req_valid && al_state == 2'h1 && al_req_state == 2'h2 && !cfg_pd
		|=> al_err && al_state == 2'h1; endproperty
	a_pd: assert property (p_pd) else $error("bad pd taken");
endmodule
`default_nettype wire

// ==== bench/fsi_test.sv ====
// fsi_test.sv: both ends joined; states, object writes, lamps
// assumes: design and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module fsi_test;
	logic        MCLK_I = 1'b0, NRST_I = 1'b0, gv = 1'b0, sv = 1'b0, alm = 1'b0;
	logic        run, err, fail, srdy, rv, ra, ev, pov, ce = 1'b1, dcm = 1'b1;
	logic [1:0]  gs = 2'h0, pli = 2'h0, act = 2'h0, pl, st, mst;
	logic [2:0]  flt = 3'h0;
	logic [7:0]  sub = 8'h00;
	logic [15:0] val = 16'h0000, pdo = 16'h0000, code = 16'h0000, md, pod, ct, pin;
	logic [31:0] rnd = 32'hc658;
	int          n_mismatch = 0, n_tests = 0, cyc = 0, c;
	wire logic [3:0] lamp = {pl, err, run};
	fsi_link_if lk (.mclk(MCLK_I));
	wire logic [3:0] hit = {rv, ev, pov, lk.al_ack};
	fsi_dev #(.BLINK_CYC(8), .DARK_CYC(20), .FLICK_CYC(4)) i_fsi_dev (.MCLK_I(MCLK_I),
		.NRST_I(NRST_I), .CE_I(ce), .lnk(lk.dev), .PORT_LINK_I(pli), .PORT_ACT_I(act),
		.DC_MODE_I(dcm), .ALARM_I(alm), .ALARM_CODE_I(code), .PD_IN_DATA_I(rnd[15:0]),
		.PD_OUT_VALID_O(pov), .PD_OUT_DATA_O(pod), .APP_TICK_O(), .AL_STATE_O(st),
		.CYCLE_TIME_O(ct), .RUN_LAMP_O(run), .ERR_LAMP_O(err), .PORT_LINK_ACTIVITY_LAMP_O(pl));
	fsi_mst #(.SYNC_CYC(16)) i_fsi_mst (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .CE_I(ce),
		.lnk(lk.mst), .GOAL_VALID_I(gv), .GOAL_STATE_I(fsi_pkg::fsi_al_e'(gs)),
		.CFG_FAULT_I(flt), .STATE_O(mst), .FAIL_O(fail), .SDO_VALID_I(sv), .SDO_SUB_I(sub),
		.SDO_VAL_I(val), .SDO_READY_O(srdy), .RSP_VALID_O(rv), .RSP_ABORT_O(ra),
		.EMCY_VALID_O(ev), .MSG_DATA_O(md), .PD_OUT_I(pdo), .PD_IN_VALID_O(), .PD_IN_O(pin));
	fsi_assertions i_fsi_assertions (.mclk(MCLK_I), .NRST_I(NRST_I),
		.al_req_valid(lk.al_req_valid), .al_req_state(lk.al_req_state), .al_state(lk.al_state),
		.al_ack(lk.al_ack), .al_err(lk.al_err), .cfg_mbx(lk.cfg_mbx), .cfg_pd(lk.cfg_pd),
		.mbx_ready(lk.mbx_ready), .sync0(lk.sync0), .pd_in_valid(lk.pd_in_valid));
	always #25 MCLK_I = ~MCLK_I;
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge MCLK_I) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t: %h not %h", $time, s, e);
		end
	endtask
	task automatic hold(input int b);
		for (c = 0; c < 400 && hit[b] !== 1'b1; c++) @(posedge MCLK_I);
		if (hit[b] !== 1'b1) chk(16'h0, 16'h1);
	endtask
	// count lit cycles; windows span whole periods so phase drops out
	task automatic lit(input int b, input int n, input int e);
		c = 0;
		repeat (n) @(posedge MCLK_I) c += int'(lamp[b] === 1'b1);
		chk(16'(c), 16'(e));
	endtask
	task automatic go(input logic [1:0] g, input logic [2:0] f, input logic [1:0] e);
		gs <= g;
		flt <= f;
		gv <= 1'b1;
		@(posedge MCLK_I) gv <= 1'b0;
		hold(0);
		repeat (2) @(posedge MCLK_I);
		chk(16'({fail, st, mst}), 16'({f != 3'h0, e, e}));
	endtask
	task automatic sdo(input logic [7:0] s, input logic [15:0] v);
		sub <= s;
		val <= v;
		sv <= 1'b1;
		do @(posedge MCLK_I); while (srdy !== 1'b1);
		sv <= 1'b0;
		hold(3);
		chk(16'(ra), 16'(s != 8'h03));
		chk(s == 8'h03 ? ct : md, s == 8'h03 ? v : {8'h00, s});
	endtask
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	initial begin
		repeat (6) @(posedge MCLK_I);
		NRST_I <= 1'b1;
		@(posedge MCLK_I) chk(16'({run, err}), 16'h0);
		go(2'h1, 3'h1, 2'h0);
		lit(1, 32, 16);
		go(2'h1, 3'h0, 2'h1);
		lit(0, 32, 16);
		repeat (12) begin
			rnd <= xs(rnd);
			sdo(rnd[0] ? 8'h03 : rnd[15:8], rnd[31:16]);
		end
		go(2'h2, 3'h2, 2'h1);
		pdo <= rnd[15:0];
		go(2'h2, 3'h0, 2'h2);
		lit(0, 56, 16);
		chk(pod, 16'h0);
		go(2'h3, 3'h0, 2'h3);
		lit(0, 8, 8);
		lit(1, 8, 0);
		hold(1);
		chk(pod, pdo);
		chk(pin, rnd[15:0]);
		code <= rnd[31:16];
		alm <= 1'b1;
		@(posedge MCLK_I) alm <= 1'b0;
		hold(2);
		chk(md, code);
		lit(3, 8, 0);
		pli <= 2'h3;
		act <= 2'h3;
		// let the lamp reach the flicker before counting whole periods
		repeat (2) @(posedge MCLK_I);
		lit(2, 16, 8);
		act <= 2'h0;
		repeat (10) @(posedge MCLK_I);
		lit(3, 20, 20);
		final_report();
	end
	task automatic final_report();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
endmodule
`default_nettype wire
